/* File: design/ssm_mem.sv */
// memory end: 64k x 32 synchronous single-port store
// assumes requester keeps strobes exclusive and holds init for 10 clocks
// assumes every link input is synchronous to clk_sys
// assumes the requester waits out the start time before any access
// Functional notes
// RULE1 - 65536 words of 32 bits, 16-bit address
// RULE2 - flow-through read, late-write data
// RULE3 - address and command captured at rising edge
// RULE4 - transfer completes in the same cycle
// RULE5 - read low reads, write low writes
// RULE6 - both strobes high is no operation
// RULE7 - requester never lowers both strobes together
// RULE8 - 32-bit active-high read data out
// RULE9 - synchronous init reset keeps stored contents
// RULE10 - clock runs two cycles before reset
// RULE11 - init reset held at least ten clocks
// RULE12 - wait 128 cycles before first access
// RULE13 - strobes ignored while init reset asserted
`timescale 1ns/1ns
`default_nettype none
`include "ssm_consts.svh"
module ssm_mem #(
    // widths
    parameter int ADDR_W = `SSM_ADDR_W,
    parameter int DATA_W = `SSM_DATA_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // link
    ssm_if.mem       lnk
);

    // one word per address value
    localparam int DEPTH = 1 << ADDR_W;
    // start-up counter width and the start wait it must reach
    localparam int               CNT_W    = `SSM_CNT_W;
    localparam logic [CNT_W-1:0] WAIT_END = CNT_W'(`SSM_START_WAIT);

    // the link types fix both widths; other values cannot be served
    if (ADDR_W != `SSM_ADDR_W) begin : g_bad_addr_w
        $error("ssm_mem: address width must match the link");
    end
    if (DATA_W != `SSM_DATA_W) begin : g_bad_data_w
        $error("ssm_mem: data width must match the link");
    end
    if (DEPTH != `SSM_DEPTH) begin : g_bad_depth
        $error("ssm_mem: depth must cover every address");
    end
    if (`SSM_START_WAIT < 1 ||
        `SSM_START_WAIT >= (1 << CNT_W)) begin : g_bad_wait
        $error("ssm_mem: start wait does not fit the counter");
    end

    // storage and read data
    logic [DATA_W-1:0]   mem_q [DEPTH]; // RULE1
    logic [DATA_W-1:0]   rdata_q;
    logic [DATA_W-1:0]   rdata_d;
    wire  [DATA_W-1:0]   dout_w;

    // decoded command
    logic                cmd_rd;
    logic                cmd_wr;
    logic                init_act;
    logic                acc_ok;
    logic                do_rd;
    logic                do_wr;
    logic [ADDR_W-1:0]   cmd_addr;
    logic [DATA_W-1:0]   cmd_wdata;

    // start-up state
    ssm_pkg::ssm_state_t st_q;
    logic [CNT_W-1:0]    cnt_q;
    logic                wait_done;

    // strobe truth table; both low is illegal and does nothing
    always_comb begin
        cmd_rd = 1'b0;
        cmd_wr = 1'b0;
        case ({lnk.rd_n, lnk.wr_n})
            2'b01: begin
                cmd_rd = 1'b1; // RULE5
                cmd_wr = 1'b0;
            end
            2'b10: begin
                cmd_rd = 1'b0;
                cmd_wr = 1'b1; // RULE5
            end
            2'b11: begin
                cmd_rd = 1'b0; // RULE6
                cmd_wr = 1'b0;
            end
            2'b00: begin
                cmd_rd = 1'b0; // RULE7
                cmd_wr = 1'b0;
            end
            default: begin
                cmd_rd = 1'b0;
                cmd_wr = 1'b0;
            end
        endcase
    end

    // init reset is a level sampled at the command edge
    assign init_act = ~lnk.init_n; // RULE9

    // reset and init force a known state; contents are not touched
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ssm_pkg::SSM_ST_RESET;
        end else if (init_act) begin
            st_q <= ssm_pkg::SSM_ST_RESET; // RULE9
        end else begin
            case (st_q)
                ssm_pkg::SSM_ST_RESET: begin
                    st_q <= ssm_pkg::SSM_ST_WAIT;
                end
                ssm_pkg::SSM_ST_WAIT: begin
                    if (wait_done) begin
                        st_q <= ssm_pkg::SSM_ST_READY;
                    end
                end
                ssm_pkg::SSM_ST_READY: begin
                    st_q <= ssm_pkg::SSM_ST_READY;
                end
                default: begin
                    st_q <= ssm_pkg::SSM_ST_RESET;
                end
            endcase
        end
    end

    // start wait counter, restarted by reset and by init
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (init_act) begin
            cnt_q <= '0;
        end else if (st_q == ssm_pkg::SSM_ST_RESET) begin
            cnt_q <= CNT_W'(1);
        end else if (st_q == ssm_pkg::SSM_ST_WAIT && !wait_done) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    assign wait_done = (cnt_q == WAIT_END - CNT_W'(1)); // RULE12

    // accesses are served only once the start wait has run out
    always_comb begin
        acc_ok = 1'b0;
        case (st_q)
            ssm_pkg::SSM_ST_RESET: begin
                acc_ok = 1'b0;
            end
            ssm_pkg::SSM_ST_WAIT: begin
                acc_ok = 1'b0;
            end
            ssm_pkg::SSM_ST_READY: begin
                acc_ok = 1'b1;
            end
            default: begin
                acc_ok = 1'b0;
            end
        endcase
    end

    // strobes are ignored during init and before start-up ends
    assign do_rd = cmd_rd & ~init_act & acc_ok; // RULE13
    assign do_wr = cmd_wr & ~init_act & acc_ok; // RULE13

    // address and late-write data as they stand at the edge
    assign cmd_addr  = lnk.addr; // RULE3
    assign cmd_wdata = lnk.wdata; // RULE2

    // write lands at its own edge; no reset touches the contents
    always_ff @(posedge clk_sys) begin
        if (rst_n && do_wr) begin
            mem_q[cmd_addr] <= cmd_wdata; // RULE4
        end
    end

    // chosen word goes straight to the output, no extra stage
    always_comb begin
        rdata_d = rdata_q;
        if (do_rd) begin
            rdata_d = mem_q[cmd_addr]; // RULE2
        end
    end

    // read data stands through the cycle after the command edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d; // RULE4
        end
    end

    // each output bit carries its stored bit, high for one
    for (genvar b = 0; b < DATA_W; b++) begin : g_dout
        assign dout_w[b] = rdata_q[b]; // RULE8
    end

    assign lnk.rdata = dout_w;
endmodule : ssm_mem
`default_nettype wire

/* File: design/ssm_consts.svh */
// constants for the synchronous single-port memory port
// assumes inclusion by bare name from package and modules
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH
`define SSM_ADDR_W       16
`define SSM_DATA_W       32
`define SSM_DEPTH        65536
`define SSM_RST_CYCLES   10
`define SSM_CLK_WARM     2
`define SSM_START_WAIT   128
`define SSM_CNT_W        8
`endif

/* File: design/ssm_pkg.sv */
// types shared by the memory end and the requester end
// assumes ssm_consts.svh is on the include path
`include "ssm_consts.svh"
package ssm_pkg;
    typedef logic [`SSM_ADDR_W-1:0] ssm_addr_t;
    typedef logic [`SSM_DATA_W-1:0] ssm_data_t;
    typedef enum logic [2:0] {
        SSM_ST_RESET = 3'h1,
        SSM_ST_WAIT  = 3'h2,
        SSM_ST_READY = 3'h4
    } ssm_state_t;
endpackage : ssm_pkg

/* File: design/ssm_if.sv */
// link between requester and memory
// assumes one clock driven by the testbench
`timescale 1ns/1ns
`default_nettype none
interface ssm_if (
    input wire logic clk_sys
);
    ssm_pkg::ssm_addr_t addr;
    logic               rd_n;
    logic               wr_n;
    ssm_pkg::ssm_data_t wdata;
    ssm_pkg::ssm_data_t rdata;
    logic               init_n;
    modport mem (input addr, rd_n, wr_n, wdata, init_n, output rdata);
    modport req (output addr, rd_n, wr_n, wdata, init_n, input rdata);
endinterface : ssm_if
`default_nettype wire

/* File: design/ssm_req.sv */
// requester end: sequences init and start wait, then issues commands
// assumes user commands are single-cycle requests
`timescale 1ns/1ns
`default_nettype none
`include "ssm_consts.svh"
module ssm_req #(
    parameter int RST_CYCLES = `SSM_RST_CYCLES,
    parameter int WAIT_CYC   = `SSM_START_WAIT
) (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               rst_n,
    // user side
    input wire logic               usr_rd,
    input wire logic               usr_wr,
    input wire ssm_pkg::ssm_addr_t usr_addr,
    input wire ssm_pkg::ssm_data_t usr_wdata,
    output logic                   usr_ready,
    output ssm_pkg::ssm_data_t     usr_rdata,
    // link
    ssm_if.req                     lnk
);
    initial begin
        if (RST_CYCLES < `SSM_RST_CYCLES || WAIT_CYC < `SSM_START_WAIT ||
            WAIT_CYC + `SSM_CLK_WARM + RST_CYCLES > 255) begin
            $error("ssm_req: bad init counts");
        end
    end

    localparam logic [7:0] INIT_END = 8'(`SSM_CLK_WARM + RST_CYCLES);
    localparam logic [7:0] WAIT_END = 8'(WAIT_CYC);

    ssm_pkg::ssm_state_t st_q;
    logic [7:0]          cnt_q;
    logic                rd_pend_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= ssm_pkg::SSM_ST_RESET;
            cnt_q <= 8'h00;
        end else begin
            case (st_q)
                ssm_pkg::SSM_ST_RESET: begin
                    // warm-up clocks then at least ten init clocks
                    if (cnt_q == INIT_END - 8'h01) begin // RULE10 RULE11
                        st_q  <= ssm_pkg::SSM_ST_WAIT;
                        cnt_q <= 8'h00;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                ssm_pkg::SSM_ST_WAIT: begin
                    if (cnt_q == WAIT_END - 8'h01) begin // RULE12
                        st_q <= ssm_pkg::SSM_ST_READY;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                ssm_pkg::SSM_ST_READY: st_q <= ssm_pkg::SSM_ST_READY;
                default:               st_q <= ssm_pkg::SSM_ST_RESET;
            endcase
        end
    end

    assign usr_ready  = (st_q == ssm_pkg::SSM_ST_READY);
    assign lnk.init_n = ~(st_q == ssm_pkg::SSM_ST_RESET && cnt_q >=
                          8'(`SSM_CLK_WARM));
    // read wins if user asks both; strobes never low together
    assign lnk.rd_n  = ~(usr_ready & usr_rd); // RULE3 RULE7
    assign lnk.wr_n  = ~(usr_ready & usr_wr & ~usr_rd); // RULE7
    assign lnk.addr  = usr_addr; // RULE3
    assign lnk.wdata = usr_wdata; // RULE4

    // capture returned word one edge after the read edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_q <= 1'b0;
            usr_rdata <= '0;
        end else begin
            rd_pend_q <= ~lnk.rd_n;
            if (rd_pend_q) begin
                usr_rdata <= lnk.rdata; // RULE4
            end
        end
    end
endmodule : ssm_req
`default_nettype wire

/* File: dv/ssm_asserts.sv */
// checker: link assertions between requester and memory
// assumes instantiation beside the link in the testbench
`timescale 1ns/1ns
`default_nettype none
module ssm_asserts (
    // link
    input wire logic               clk_sys,
    input wire logic               rst_n,
    input wire ssm_pkg::ssm_addr_t addr,
    input wire logic               rd_n,
    input wire logic               wr_n,
    input wire ssm_pkg::ssm_data_t wdata,
    input wire ssm_pkg::ssm_data_t rdata,
    input wire logic               init_n
);
    logic [7:0] up_q;
    logic [7:0] lo_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // cycles since init released
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) up_q <= 8'h00;
        else if (!init_n) up_q <= 8'h00;
        else if (up_q != 8'hff) up_q <= up_q + 8'h01;
    end
    // cycles init has been held low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) lo_q <= 8'h00;
        else if (init_n) lo_q <= 8'h00;
        else if (lo_q != 8'hff) lo_q <= lo_q + 8'h01;
    end
    sequence s_wr_rd;
        !wr_n && init_n ##1 !rd_n && addr == $past(addr);
    endsequence
    sequence s_rd_rd;
        !rd_n ##1 !rd_n && addr == $past(addr);
    endsequence
    property p_excl; !(!rd_n && !wr_n); endproperty
    property p_warm; $rose(rst_n) |-> init_n[*2] ##1 !init_n; endproperty
    property p_ilen; $rose(init_n) |-> lo_q >= 8'd10; endproperty
    property p_wait; !rd_n || !wr_n |-> up_q >= 8'd128; endproperty
    property p_wr_rd; s_wr_rd |=> rdata == $past(wdata, 2); endproperty
    property p_hold; rd_n |=> $stable(rdata); endproperty
    property p_quiet; !init_n |-> rd_n && wr_n; endproperty
    property p_reread; s_rd_rd |=> rdata == $past(rdata); endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    a_warm: assert property (p_warm) else $error("init too early");
    a_ilen: assert property (p_ilen) else $error("init length");
    a_wait: assert property (p_wait) else $error("access too early");
    a_wr_rd: assert property (p_wr_rd) else $error("read after write");
    a_hold: assert property (p_hold) else $error("rdata moved");
    a_quiet: assert property (p_quiet) else $error("strobe in init");
    a_reread: assert property (p_reread) else $error("reread");
endmodule : ssm_asserts
`default_nettype wire

/* File: dv/testbench.sv */
// testbench: requester and memory joined by the link
// assumes the design files are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic               clk_sys   = 1'b0;
    logic               rst_n     = 1'b0;
    logic               usr_rd    = 1'b0;
    logic               usr_wr    = 1'b0;
    ssm_pkg::ssm_addr_t usr_addr  = 16'h0000;
    ssm_pkg::ssm_data_t usr_wdata = 32'h0000_0000;
    logic               usr_ready;
    ssm_pkg::ssm_data_t usr_rdata;
    int                 n_errors  = 0;
    int                 checks_done = 0;
    always #10 clk_sys = ~clk_sys;
    ssm_if lnk (.clk_sys(clk_sys));
    ssm_mem ssm_mem_i (.clk_sys(clk_sys), .rst_n(rst_n), .lnk(lnk));
    ssm_req ssm_req_i (.clk_sys(clk_sys), .rst_n(rst_n), .usr_rd(usr_rd),
        .usr_wr(usr_wr), .usr_addr(usr_addr), .usr_wdata(usr_wdata),
        .usr_ready(usr_ready), .usr_rdata(usr_rdata), .lnk(lnk));
    ssm_asserts ssm_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .addr(lnk.addr), .rd_n(lnk.rd_n), .wr_n(lnk.wr_n),
        .wdata(lnk.wdata), .rdata(lnk.rdata), .init_n(lnk.init_n));
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // outputs are looked at mid-cycle, where they have settled
    task automatic cmp_word(input ssm_pkg::ssm_data_t exp);
        @(negedge clk_sys);
        checks_done++;
        if (usr_rdata !== exp) begin
            n_errors++;
            $display("unexpected at %0t: word %h want %h", $time,
                     usr_rdata, exp);
        end
        @(posedge clk_sys);
    endtask : cmp_word
    task automatic cmp_flag(input logic exp);
        @(negedge clk_sys);
        checks_done++;
        if (usr_ready !== exp) begin
            n_errors++;
            $display("unexpected at %0t: ready %b want %b", $time,
                     usr_ready, exp);
        end
        @(posedge clk_sys);
    endtask : cmp_flag
    task automatic acc(input logic r, w, input ssm_pkg::ssm_addr_t a,
                       input ssm_pkg::ssm_data_t d);
        usr_rd <= r;
        usr_wr <= w;
        usr_addr <= a;
        usr_wdata <= d;
        @(posedge clk_sys);
    endtask : acc
    task automatic idle;
        usr_rd <= 1'b0;
        usr_wr <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask : idle
    // reset, a dropped write during init, then the start wait
    task automatic boot;
        rst_n <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        acc(1'b0, 1'b1, 16'h0000, 32'h0000_0000);
        idle;
        repeat (130) @(posedge clk_sys);
        cmp_flag(1'b0);
        cmp_flag(1'b1);
        $display("test boot done");
    endtask : boot
    initial begin
        #40000;
        n_errors++;
        results;
    end
    initial begin
        automatic ssm_pkg::ssm_addr_t a[3] = '{16'h0000, 16'h8000, 16'hffff};
        boot;
        foreach (a[i]) begin
            acc(1'b0, 1'b1, a[i], {~a[i], a[i]});
            acc(1'b1, 1'b0, a[i], 32'h0000_0000);
            acc(1'b1, 1'b0, a[i], 32'h0000_0000);
            idle;
            cmp_word({~a[i], a[i]});
        end
        $display("test fill done");
        acc(1'b1, 1'b1, 16'h8000, 32'h1234_5678);
        idle;
        cmp_word(32'h7fff_8000);
        acc(1'b1, 1'b0, 16'h8000, 32'h0000_0000);
        idle;
        cmp_word(32'h7fff_8000);
        $display("test clash done");
        boot;
        acc(1'b1, 1'b0, 16'h0000, 32'h0000_0000);
        idle;
        cmp_word(32'hffff_0000);
        $display("test rerun done");
        results;
    end
endmodule : testbench
`default_nettype wire
